// ===== sbi_cpu_model.sv
// behavioural processor model at the far side of the controller
`timescale 1ns/1ps
`include "sbi_map.vh"
module sbi_cpu_model
(
  input wire aclk, // clock
  input wire aresetn, // reset, low active
  input wire [39:4] addr_out, // address drive
  input wire addr_oe, // address enable
  input wire [3:0] cmd_out, // command drive
  input wire cmd_oe, // command enable
  input wire addr_bus_req, // bus request
  input wire cack, // command ack
  input wire dack, // data ack
  input wire data_bus_req, // data request
  input wire fill_warn, // fill warning
  input wire fill_miss_select, // fill slot
  input wire fill_error, // fill error
  input wire board_cache_hold, // cache idle
  input wire issue, // bench command
  input wire [3:0] issue_cmd, // code
  input wire [39:4] issue_addr, // address
  input wire [3:0] issue_lane, // lane mask
  output wire [39:4] addr_in, // address level
  output wire [3:0] cmd_in, // command level
  output reg [1:0] addr_res, // probe reply
  output reg [3:0] lane_valid_mask, // lane mask
  output reg drive_data, // data drive next
  output reg [39:4] bc_addr, // fill address
  output reg [7:0] machine_check_trap_count // traps taken
);
  // ****
  // bus levels and reactions
  // ****
  reg [3:0] my_cmd, last_cmd;
  reg [39:4] my_addr, last_addr, miss0, miss1;
  reg pend, bc_write, bc_private;
  // a released bus toggles so a stale value is never mistaken for a drive
  assign cmd_in = cmd_oe ? cmd_out : (addr_bus_req ? ~last_cmd : my_cmd);
  assign addr_in = addr_oe ? addr_out : (addr_bus_req ? ~last_addr : my_addr);
  always @(posedge aclk)
  begin
    last_cmd <= cmd_in;
    last_addr <= addr_in;
    if (!aresetn)
    begin
      pend <= 1'b0;
      my_cmd <= `SBI_CMD_IDLE;
      my_addr <= 36'h0;
      addr_res <= `SBI_RESP_NOTHING;
      lane_valid_mask <= 4'h0;
      drive_data <= 1'b0;
      bc_addr <= 36'h0;
      machine_check_trap_count <= 8'h00;
      bc_write <= 1'b0;
      bc_private <= 1'b0;
    end
    else
    begin
      drive_data <= !data_bus_req;
      bc_private <= !board_cache_hold && !fill_warn;
      bc_write <= fill_warn || (bc_write && !dack);
      if (fill_warn)
        bc_addr <= fill_miss_select ? miss1 : miss0;
      if (fill_error)
        machine_check_trap_count <= machine_check_trap_count + 8'h01;
      if (cmd_oe)
        addr_res <= (cmd_out == `SBI_CMD_INVAL) ? `SBI_RESP_MISS_OR_CLEAN : `SBI_RESP_FROM_CACHE;
      if (issue && !pend)
      begin
        pend <= 1'b1;
        my_cmd <= issue_cmd;
        my_addr <= issue_addr;
        lane_valid_mask <= issue_lane;
        if (issue_cmd == `SBI_CPU_MISS_ONE)
          miss1 <= issue_addr;
        if (issue_cmd == `SBI_CPU_MISS_ZERO)
          miss0 <= issue_addr;
      end
      if (pend && cack)
      begin
        pend <= 1'b0;
        my_cmd <= `SBI_CMD_IDLE;
      end
    end
  end
endmodule

// ===== sbi_ctrl.v
// system-side bus controller: drives the processor bus pins from axi4-lite registers
`timescale 1ns/1ps
`include "sbi_map.vh"
module sbi_ctrl
(
  input wire aclk, // 125 MHz system clock
  input wire aresetn, // synchronous reset, low active
  input wire [31:0] s_axi_awaddr, // write address
  input wire s_axi_awvalid, // write address valid
  output reg s_axi_awready, // write address ready
  input wire [31:0] s_axi_wdata, // write data
  input wire [3:0] s_axi_wstrb, // write strobes
  input wire s_axi_wvalid, // write data valid
  output reg s_axi_wready, // write data ready
  output reg [1:0] s_axi_bresp, // write response
  output reg s_axi_bvalid, // write response valid
  input wire s_axi_bready, // write response ready
  input wire [31:0] s_axi_araddr, // read address
  input wire s_axi_arvalid, // read address valid
  output reg s_axi_arready, // read address ready
  output reg [31:0] s_axi_rdata, // read data
  output reg [1:0] s_axi_rresp, // read response
  output reg s_axi_rvalid, // read data valid
  input wire s_axi_rready, // read data ready
  input wire [39:4] addr_in, // address bus level seen at pins
  output reg [39:4] addr_out, // address bus drive value
  output reg addr_oe, // address bus drive enable
  input wire [3:0] cmd_in, // command bus level seen at pins
  output reg [3:0] cmd_out, // command bus drive value
  output reg cmd_oe, // command bus drive enable
  output reg addr_bus_req, // address bus request
  input wire [1:0] addr_res, // processor probe response
  output reg cack, // command acknowledge
  output reg dack, // data acknowledge
  output reg data_bus_req, // data bus request
  output reg fill_warn, // fill warning
  output reg fill_miss_select, // fill identification
  output reg fill_dirty, // fill dirty
  output reg fill_error, // fill error
  output reg board_cache_hold, // board cache idle request
  input wire [3:0] lane_valid_mask, // lane-valid mask from processor
  output reg [1:0] clk_mode // clock mode straps
);
  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  wire [47:0] sync_q;
  sbi_sync #(.W(48)) u_sync
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .d({lane_valid_mask, addr_res, cmd_in, addr_in, 2'b00}),
    .q(sync_q)
  );
  wire [35:0] pin_addr = sync_q[37:2];
  wire [3:0] pin_cmd = sync_q[41:38];
  wire [1:0] pin_res = sync_q[43:42];
  wire [3:0] pin_lane = sync_q[47:44];
  // ****************************************************************
  // software registers
  // ****************************************************************
  reg [31:0] ctrl;
  reg [3:0] sys_cmd;
  reg [35:0] sys_addr;
  reg [3:0] cpu_cmd;
  reg [35:0] cpu_addr;
  reg [3:0] cpu_lane;
  reg cpu_valid;
  reg [1:0] last_resp;
  reg [7:0] machine_check_trap_count;
  reg [3:0] fill_ctl;
  reg fill_active;
  reg [7:0] hold_cnt;
  reg aw_hold;
  reg w_hold;
  reg [7:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  reg cmd_go;
  reg fill_go;
  reg [1:0] cack_gap;
  // system command state machine
  localparam ST_IDLE = 2'b00;
  localparam ST_DRIVE = 2'b01;
  localparam ST_RELEASE = 2'b10;
  reg [1:0] state;
  reg [1:0] next_state;
  wire io_ref = cpu_addr[`SBI_ADDR_IO_BIT - 4];
  wire [1:0] io_size = cpu_addr[38 - 4 -: 2];
  // decoded processor command is a known request, reserved codes ignored
  wire cpu_cmd_known = (pin_cmd == `SBI_CPU_WRITE_BLOCK) ||
    (pin_cmd == `SBI_CPU_MISS_ZERO) || (pin_cmd == `SBI_CPU_MISS_ONE) ||
    (pin_cmd == `SBI_CPU_VICTIM);
  // ****************************************************************
  // axi4-lite write channel
  // ****************************************************************
  wire do_write = aw_hold && w_hold && !s_axi_bvalid;
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      ctrl <= `SBI_CTRL_RESET;
      sys_cmd <= `SBI_CMD_IDLE;
      sys_addr <= 36'h0_0000_0000;
      fill_ctl <= 4'h0;
      cmd_go <= 1'b0;
      fill_go <= 1'b0;
    end
    else
    begin
      cmd_go <= 1'b0;
      fill_go <= 1'b0;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold <= 1'b1;
        aw_addr <= s_axi_awaddr[7:0];
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write)
      begin
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= 2'h0;
        case (aw_addr)
          `SBI_REG_CTRL:
            ctrl <= w_data & 32'h0000_001F;
          `SBI_REG_CMD:
          begin
            sys_cmd <= w_data[3:0];
            cmd_go <= (state == ST_IDLE);
          end
          `SBI_REG_ADDR_LO:
            sys_addr[27:0] <= w_data[31:4];
          `SBI_REG_ADDR_HI:
            sys_addr[35:28] <= w_data[7:0];
          `SBI_REG_FILL:
          begin
            fill_ctl <= w_data[3:0];
            fill_go <= w_data[`SBI_FILL_GO] && !fill_active;
          end
          `SBI_REG_STATUS:
            ;
          default:
            s_axi_bresp <= 2'h2;
        endcase
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end
  // ****************************************************************
  // axi4-lite read channel
  // ****************************************************************
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end
    else if (s_axi_rvalid)
    begin
      if (s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'h0;
      s_axi_rdata <= 32'h0000_0000;
      case (s_axi_araddr[7:0])
        `SBI_REG_CTRL: s_axi_rdata <= ctrl;
        `SBI_REG_CMD: s_axi_rdata <= {28'h000_0000, sys_cmd};
        `SBI_REG_ADDR_LO: s_axi_rdata <= {sys_addr[27:0], 4'h0};
        `SBI_REG_ADDR_HI: s_axi_rdata <= {24'h00_0000, sys_addr[35:28]};
        `SBI_REG_STATUS:
          s_axi_rdata <= {17'h0_0000, io_size, io_ref, cpu_lane, 2'b00,
            last_resp, 1'b0, fill_active, (state != ST_IDLE), cpu_valid};
        `SBI_REG_CPU_CMD: s_axi_rdata <= {28'h000_0000, cpu_cmd};
        `SBI_REG_CPU_ADDR_LO: s_axi_rdata <= {cpu_addr[27:0], 4'h0};
        `SBI_REG_CPU_ADDR_HI: s_axi_rdata <= {24'h00_0000, cpu_addr[35:28]};
        `SBI_REG_FILL: s_axi_rdata <= {28'h000_0000, fill_ctl};
        `SBI_REG_COUNT: s_axi_rdata <= {24'h00_0000, machine_check_trap_count};
        default: s_axi_rresp <= 2'h2;
      endcase
    end
  end
  // ****************************************************************
  // system command sequencer
  // ****************************************************************
  always @*
  begin
    next_state = state;
    case (state)
      ST_IDLE:
        if (cmd_go)
          next_state = ST_DRIVE;
      ST_DRIVE:
        next_state = ST_RELEASE;
      ST_RELEASE:
        next_state = ST_IDLE;
      default:
        next_state = ST_IDLE;
    endcase
  end
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state <= ST_IDLE;
      addr_bus_req <= 1'b0;
      addr_out <= 36'h0_0000_0000;
      addr_oe <= 1'b0;
      cmd_out <= `SBI_CMD_IDLE;
      cmd_oe <= 1'b0;
      cack <= 1'b0;
      cpu_cmd <= `SBI_CMD_IDLE;
      cpu_addr <= 36'h0_0000_0000;
      cpu_lane <= 4'h0;
      cpu_valid <= 1'b0;
      last_resp <= `SBI_RESP_NOTHING;
      clk_mode <= 2'b00;
      data_bus_req <= 1'b0;
      cack_gap <= 2'h0;
    end
    else
    begin
      state <= next_state;
      clk_mode <= ctrl[`SBI_CTRL_CLKMODE_HI:`SBI_CTRL_CLKMODE_LO];
      data_bus_req <= ctrl[`SBI_CTRL_DBUS_REQ];
      // bus stays requested for the command and one turnaround cycle
      addr_bus_req <= ctrl[`SBI_CTRL_ABUS_REQ] || (next_state != ST_IDLE);
      addr_oe <= (next_state == ST_DRIVE);
      cmd_oe <= (next_state == ST_DRIVE);
      addr_out <= sys_addr;
      cmd_out <= (next_state == ST_DRIVE) ? sys_cmd : `SBI_CMD_IDLE;
      if (pin_res != `SBI_RESP_NOTHING)
        last_resp <= pin_res;
      // synced pins lag two edges, three after cack: without this gap an acked or echoed code is taken twice
      if (cack || addr_bus_req)
        cack_gap <= `SBI_CACK_GAP;
      else if (cack_gap != 2'h0)
        cack_gap <= cack_gap - 2'h1;
      // only sample the processor's commands while it owns the bus
      cack <= 1'b0;
      if (cack_gap == 2'h0 && !addr_bus_req && !cmd_oe && cpu_cmd_known && !cack)
      begin
        cack <= 1'b1;
        cpu_cmd <= pin_cmd;
        cpu_addr <= pin_addr;
        cpu_lane <= pin_lane;
        cpu_valid <= 1'b1;
      end
      else if (s_axi_arvalid && s_axi_arready && s_axi_araddr[7:0] == `SBI_REG_CPU_CMD)
        cpu_valid <= 1'b0;
    end
  end
  // ****************************************************************
  // fill sequencer
  // ****************************************************************
  // hold is raised a fixed lead ahead of fill data so the cache goes quiet
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      fill_active <= 1'b0;
      hold_cnt <= 8'h00;
      fill_warn <= 1'b0;
      fill_miss_select <= 1'b0;
      fill_dirty <= 1'b0;
      fill_error <= 1'b0;
      dack <= 1'b0;
      board_cache_hold <= 1'b0;
      machine_check_trap_count <= 8'h00;
    end
    else
    begin
      fill_warn <= 1'b0;
      dack <= 1'b0;
      board_cache_hold <= ctrl[`SBI_CTRL_HOLD] || fill_go || (fill_active && hold_cnt != 8'h00);
      if (fill_go)
      begin
        fill_active <= 1'b1;
        hold_cnt <= `SBI_HOLD_LEAD;
        fill_miss_select <= fill_ctl[`SBI_FILL_SLOT];
        fill_dirty <= fill_ctl[`SBI_FILL_DIRTY];
      end
      else if (fill_active && hold_cnt != 8'h00)
      begin
        hold_cnt <= hold_cnt - 8'h01;
        if (hold_cnt == 8'h01)
        begin
          fill_warn <= 1'b1;
        end
      end
      else if (fill_active && fill_warn)
      begin
        // data cycle: acknowledge so the processor does not retry
        dack <= 1'b1;
        fill_error <= fill_ctl[`SBI_FILL_ERROR];
        if (fill_ctl[`SBI_FILL_ERROR])
          machine_check_trap_count <= machine_check_trap_count + 8'h01;
      end
      else if (fill_active)
      begin
        fill_active <= 1'b0;
        fill_error <= 1'b0;
        fill_dirty <= 1'b0;
        fill_miss_select <= 1'b0;
      end
    end
  end
endmodule

// ===== sbi_ctrl_properties.sv
// concurrent checks on the pins of the system bus controller
`timescale 1ns/1ps
`include "sbi_map.vh"
module sbi_ctrl_properties
(
  input wire aclk, // clock
  input wire aresetn, // reset, low active
  input wire addr_oe, // address enable
  input wire cmd_oe, // command enable
  input wire [3:0] cmd_out, // command drive
  input wire addr_bus_req, // bus request
  input wire cack, // command ack
  input wire dack, // data ack
  input wire fill_warn, // fill warning
  input wire fill_miss_select, // fill slot
  input wire fill_error, // fill error
  input wire board_cache_hold // cache idle
);
  // ****
  // pin relations
  // ****
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence fill_hand;
    fill_warn ##1 dack;
  endsequence
  AST_OWN_CMD: assert property (cmd_oe |-> addr_bus_req) else $error("cmd without bus");
  AST_OE_PAIR: assert property (addr_oe == cmd_oe) else $error("enables split");
  AST_CMD_CODE: assert property (cmd_oe |-> cmd_out inside {`SBI_CMD_IDLE, `SBI_CMD_FLUSH,
    `SBI_CMD_INVAL, `SBI_CMD_READ}) else $error("reserved command");
  AST_HOLD_LEAD: assert property (fill_warn |-> board_cache_hold && $past(board_cache_hold, 2))
    else $error("hold too late");
  AST_FILL_ACK: assert property (fill_warn |-> fill_hand) else $error("no data ack");
  AST_ERR_DATA: assert property (fill_error |-> dack) else $error("error off data");
  AST_DACK_PULSE: assert property (dack |=> !dack) else $error("dack too long");
  AST_CACK_PULSE: assert property (cack |-> !cmd_oe ##1 !cack) else $error("bad cack");
  AST_CACK_ONCE: assert property (cack |=> !cack [*3]) else $error("cack repeated");
  AST_SLOT_HOLD: assert property (fill_warn |=> $stable(fill_miss_select))
    else $error("slot moved");
endmodule
bind sbi_ctrl sbi_ctrl_properties u_sbi_ctrl_properties (.aclk, .aresetn, .addr_oe, .cmd_oe,
  .cmd_out, .addr_bus_req, .cack, .dack, .fill_warn, .fill_miss_select, .fill_error,
  .board_cache_hold);

// ===== sbi_map.vh
// register map, field positions and bus encodings for the system bus controller
`ifndef SBI_MAP_VH
`define SBI_MAP_VH
// ****************************************************************
// register offsets (byte addresses)
// ****************************************************************
`define SBI_REG_CTRL 8'h00
`define SBI_REG_CMD 8'h04
`define SBI_REG_ADDR_LO 8'h08
`define SBI_REG_ADDR_HI 8'h0C
`define SBI_REG_STATUS 8'h10
`define SBI_REG_CPU_CMD 8'h14
`define SBI_REG_CPU_ADDR_LO 8'h18
`define SBI_REG_CPU_ADDR_HI 8'h1C
`define SBI_REG_FILL 8'h20
`define SBI_REG_COUNT 8'h24
// ****************************************************************
// control fields
// ****************************************************************
`define SBI_CTRL_ABUS_REQ 0
`define SBI_CTRL_DBUS_REQ 1
`define SBI_CTRL_HOLD 2
`define SBI_CTRL_CLKMODE_LO 3
`define SBI_CTRL_CLKMODE_HI 4
`define SBI_CTRL_RESET 32'h0000_0000
// fill register fields
`define SBI_FILL_GO 0
`define SBI_FILL_SLOT 1
`define SBI_FILL_DIRTY 2
`define SBI_FILL_ERROR 3
// status fields
`define SBI_ST_CPU_VALID 0
`define SBI_ST_BUSY 1
`define SBI_ST_FILL_ACTIVE 2
`define SBI_ST_RESP_LO 4
`define SBI_ST_RESP_HI 5
`define SBI_ST_LANE_LO 8
`define SBI_ST_LANE_HI 11
`define SBI_ST_IO 12
`define SBI_ST_SIZE_LO 13
`define SBI_ST_SIZE_HI 14
// ****************************************************************
// command and response codes
// ****************************************************************
`define SBI_CMD_IDLE 4'h0
`define SBI_CMD_FLUSH 4'h1
`define SBI_CMD_INVAL 4'h2
`define SBI_CMD_READ 4'h4
`define SBI_CPU_WRITE_BLOCK 4'h6
`define SBI_CPU_MISS_ZERO 4'h8
`define SBI_CPU_MISS_ONE 4'h9
`define SBI_CPU_VICTIM 4'hC
`define SBI_RESP_NOTHING 2'h0
`define SBI_RESP_MISS_OR_CLEAN 2'h1
`define SBI_RESP_FROM_CACHE 2'h3
`define SBI_ADDR_IO_BIT 39
`define SBI_HOLD_LEAD 8'h02
`define SBI_CACK_GAP 2'h3
`endif

// ===== sbi_sync.v
// two-flop synchroniser bank for device-side pin inputs
`timescale 1ns/1ps
module sbi_sync #(parameter W = 1)
(
  input wire aclk, // system clock
  input wire aresetn, // synchronous reset, low active
  input wire [W-1:0] d, // asynchronous inputs
  output reg [W-1:0] q // synchronised outputs
);
  reg [W-1:0] meta;
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta <= {W{1'b0}};
      q <= {W{1'b0}};
    end
    else
    begin
      meta <= d;
      q <= meta;
    end
  end
endmodule

// ===== tb_top.sv
// self-checking bench for the system bus controller
`timescale 1ns/1ps
`include "sbi_map.vh"
module tb_top;
  reg aclk = 1'b0;
  reg aresetn = 1'b0;
  reg [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
  reg [3:0] s_axi_wstrb = 4'hF, issue_cmd = 4'h0, issue_lane = 4'h0;
  reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  reg s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, issue = 1'b0;
  reg [39:4] issue_addr = 36'h0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp, addr_res, clk_mode;
  wire [31:0] s_axi_rdata;
  wire [39:4] addr_in, addr_out, bc_addr;
  wire [3:0] cmd_in, cmd_out, lane_valid_mask;
  wire addr_oe, cmd_oe, addr_bus_req, cack, dack, data_bus_req, fill_warn, fill_miss_select;
  wire fill_dirty, fill_error, board_cache_hold, drive_data;
  wire [7:0] machine_check_trap_count;
  integer failures = 0, cmp_count = 0, i, n;
  reg [31:0] rd;
  reg [1:0] rr;
  always #4 aclk = ~aclk;
  sbi_ctrl u_sbi_ctrl (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .addr_in, .addr_out, .addr_oe, .cmd_in, .cmd_out, .cmd_oe,
    .addr_bus_req, .addr_res, .cack, .dack, .data_bus_req, .fill_warn, .fill_miss_select,
    .fill_dirty, .fill_error, .board_cache_hold, .lane_valid_mask, .clk_mode);
  sbi_cpu_model u_sbi_cpu_model (.aclk, .aresetn, .addr_out, .addr_oe, .cmd_out, .cmd_oe,
    .addr_bus_req, .cack, .dack, .data_bus_req, .fill_warn, .fill_miss_select, .fill_error,
    .board_cache_hold, .issue, .issue_cmd, .issue_addr, .issue_lane, .addr_in, .cmd_in,
    .addr_res, .lane_valid_mask, .drive_data, .bc_addr, .machine_check_trap_count);
  // ****
  // shared tasks
  // ****
  task finish_test;
    begin
      if (failures == 0 && cmp_count > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  task chk(input [39:0] got, input [39:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp)
      begin
        failures = failures + 1;
        $display("Error at %0t: got %0h expected %0h", $time, got, exp);
      end
    end
  endtask
  task axw(input [7:0] a, input [31:0] d);
    reg [2:0] f;
    begin
      @(posedge aclk);
      s_axi_awaddr <= {24'h0, a};
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      f = 3'b000;
      while (f != 3'b111)
      begin
        @(posedge aclk);
        if (s_axi_bvalid && !f[2])
          rr = s_axi_bresp;
        f = f | {s_axi_bvalid, s_axi_wready, s_axi_awready};
        s_axi_awvalid <= !f[0];
        s_axi_wvalid <= !f[1];
        s_axi_bready <= !f[2];
      end
    end
  endtask
  task axr(input [7:0] a);
    reg [1:0] f;
    begin
      @(posedge aclk);
      s_axi_araddr <= {24'h0, a};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      f = 2'b00;
      while (f != 2'b11)
      begin
        @(posedge aclk);
        if (s_axi_rvalid && f[0])
        begin
          rd = s_axi_rdata;
          rr = s_axi_rresp;
        end
        f = f | {s_axi_rvalid & f[0], s_axi_arready};
        s_axi_arvalid <= !f[0];
        s_axi_rready <= !f[1];
      end
    end
  endtask
  // ****
  // scenarios
  // ****
  task t_ctrl;
    begin
      axr(`SBI_REG_CTRL);
      chk(40'(rd), 40'(`SBI_CTRL_RESET));
      axw(`SBI_REG_CTRL, 32'h0000_000A);
      repeat (3) @(posedge aclk);
      chk(40'({clk_mode, data_bus_req, drive_data}), 40'h6);
      axw(`SBI_REG_CTRL, 32'h0);
      repeat (3) @(posedge aclk);
      chk(40'({clk_mode, data_bus_req, drive_data}), 40'h1);
    end
  endtask
  task t_syscmd;
    reg [3:0] c;
    begin
      for (i = 0; i < 3; i = i + 1)
      begin
        c = (i == 0) ? `SBI_CMD_FLUSH : (i == 1) ? `SBI_CMD_INVAL : `SBI_CMD_READ;
        axw(`SBI_REG_ADDR_LO, {24'h123456, 4'(i), 4'h0});
        axw(`SBI_REG_ADDR_HI, 32'h0000_0012);
        axw(`SBI_REG_CMD, {28'h0, c});
        n = 0;
        while (cmd_oe !== 1'b1 && n < 20)
        begin
          @(posedge aclk);
          n = n + 1;
        end
        chk(40'({addr_bus_req, addr_oe, cmd_out}), 40'({2'b11, c}));
        chk(40'(addr_out), 40'({8'h12, 24'h123456, 4'(i)}));
        repeat (6) @(posedge aclk);
        axr(`SBI_REG_STATUS);
        chk(40'(rd[5:4]), (i == 1) ? 40'h1 : 40'h3);
      end
    end
  endtask
  task t_cpucmd;
    reg [39:4] a;
    reg [3:0] c;
    reg [3:0] m;
    begin
      for (i = 0; i < 4; i = i + 1)
      begin
        c = (i == 0) ? `SBI_CPU_WRITE_BLOCK : (i == 1) ? `SBI_CPU_MISS_ZERO :
          (i == 2) ? `SBI_CPU_MISS_ONE : `SBI_CPU_VICTIM;
        a = {(i == 0) ? 4'hE : 4'h0, 4'(i), 28'h00ABC00};
        m = 4'h5 ^ 4'(i * 3);
        @(posedge aclk);
        issue <= 1'b1;
        issue_cmd <= c;
        issue_addr <= a;
        issue_lane <= m;
        @(posedge aclk);
        issue <= 1'b0;
        n = 0;
        while (cack !== 1'b1 && n < 20)
        begin
          @(posedge aclk);
          n = n + 1;
        end
        chk(40'(cack), 40'h1);
        n = 0;
        repeat (4)
        begin
          @(posedge aclk);
          n = n + cack;
        end
        chk(40'(n), 40'h0);
        axr(`SBI_REG_STATUS);
        chk(40'({rd[14:8], rd[0]}), 40'({a[38:37], a[39], m, 1'b1}));
        axr(`SBI_REG_CPU_ADDR_HI);
        chk(40'(rd[7:0]), 40'(a[39:32]));
        axr(`SBI_REG_CPU_CMD);
        chk(40'(rd[3:0]), 40'(c));
      end
    end
  endtask
  task t_fill;
    reg [3:0] f;
    begin
      for (i = 0; i < 4; i = i + 1)
      begin
        f = {i[1], ~i[0], i[0], 1'b1};
        axw(`SBI_REG_FILL, {28'h0, f});
        n = 0;
        while (fill_warn !== 1'b1 && n < 20)
        begin
          @(posedge aclk);
          n = n + 1;
        end
        chk(40'({board_cache_hold, fill_miss_select, fill_dirty}), 40'({1'b1, f[1], f[2]}));
        @(posedge aclk);
        chk(40'({dack, fill_error}), 40'({1'b1, f[3]}));
        chk(40'(bc_addr), 40'({4'h0, 4'(i[0] + 1), 28'h00ABC00}));
      end
      axr(`SBI_REG_COUNT);
      chk(40'({rd, machine_check_trap_count}), 40'h0000_0002_02);
      axr(8'h40);
      chk(40'(rr), 40'h2);
      axw(8'h40, 32'h0000_0001);
      chk(40'(rr), 40'h2);
    end
  endtask
  initial
  begin
    #200000;
    failures = failures + 1;
    finish_test;
  end
  initial
  begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_ctrl;
    t_syscmd;
    t_cpucmd;
    t_fill;
    finish_test;
  end
endmodule
